// [inc/smec_pkg.sv]
// Constants and types shared by the secure mode entry and setup logic
`default_nettype none
package smec_pkg;
  // Core clock rate and interrupt pulse times
  localparam int CLK_MHZ = 100;
  localparam int INT_LONG_US = 100;
  localparam int INT_SHORT_US = 25;
  localparam int INT_LONG_CYC = INT_LONG_US * CLK_MHZ;
  localparam int INT_SHORT_CYC = INT_SHORT_US * CLK_MHZ;
  // Longest watchdog timeout reachable in extended-watchdog mode, seconds
  localparam int WD_EXT_MAX_S = 32;
  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WR_BIT = 14;
  localparam int FRAME_PAR_BIT = 8;
  localparam logic [4:0] ADDR_MISC = 5'h08;
  localparam logic [4:0] ADDR_SPECIAL = 5'h09;
  localparam logic [15:0] READ_KEY_CMD = 16'h1300;
  // Setup register fields and reset value
  localparam int MISC_KEYREQ = 7;
  localparam int MISC_PARITY = 6;
  localparam int MISC_INTLVL = 5;
  localparam int MISC_INTW = 4;
  localparam int MISC_HALFWD = 3;
  localparam int MISC_OVR = 2;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // Target codes of the special-mode register
  localparam logic [1:0] TGT_RESET = 2'h0;
  localparam logic [1:0] TGT_CONFIG = 2'h1;
  localparam logic [1:0] TGT_XWD = 2'h2;
  // Key generator seed, any nonzero value
  localparam logic [5:0] KEY_SEED = 6'h2d;
  // Device modes
  typedef enum logic [3:0] {
    SMEC_NORMAL = 4'b0001,
    SMEC_CONFIG = 4'b0010,
    SMEC_XWD = 4'b0100,
    SMEC_RESET = 4'b1000
  } smec_mode_t;
endpackage : smec_pkg
`default_nettype wire

// [hdl/smec_int_pulse.sv]
// Interrupt pin shaper: timed low pulse or held low level
`default_nettype none
module smec_int_pulse
  import smec_pkg::*;
#(
  parameter int LONG_CYC = INT_LONG_CYC,
  parameter int SHORT_CYC = INT_SHORT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic trigger,
  input wire logic levelMode,
  input wire logic shortWidth,
  input wire logic intAck,
  output logic intN
);
  logic [15:0] cnt;
  wire logic [15:0] loadCnt = shortWidth ? 16'(SHORT_CYC - 1) : 16'(LONG_CYC - 1);
  wire logic busy = ~intN;

  // Pulse countdown, or hold until acknowledged in level mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intN <= 1'b1;
      cnt <= 16'h0000;
    end else if (clkEn) begin
      if (trigger && !busy) begin
        intN <= 1'b0;
        cnt <= loadCnt;
      end else if (busy && levelMode) begin
        if (intAck && !trigger) intN <= 1'b1;
      end else if (busy) begin
        if (cnt == 16'h0000) intN <= 1'b1;
        else cnt <= cnt - 16'h0001;
      end
    end
  end
endmodule : smec_int_pulse
`default_nettype wire

// [hdl/smec_top.sv]
// Secured special-mode entry and miscellaneous setup register
`default_nettype none
// Function
// - Key bit gates low-power entry on key
// - Parity bit checked on writes when enabled
// - Interrupt pin pulses or holds low level
// - Pulse width 100 us or 25 us
// - Half-period interrupt in extended-watchdog mode
// - Override field decodes to fail-safe scheme
// - Strap mismatch sets debug-resistor flag
// - Software scheme overrides strap when enabled
// - Target field selects reset, config, watchdog
// - Write carries inverse of last key, low four bits only for fail-safe
// - Config entry from normal mode by write or from reset mode on exit
// - Fail-safe pin set low only in config, held until reset
// - Reset and watchdog entry use exchange
// - Extended-watchdog mode allows 32 s timeout
// - Setup writes accepted only in config
module smec_top
  import smec_pkg::*;
#(
  parameter int INT_LONG = INT_LONG_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiMosi,
  output logic spiMiso,
  input wire logic [1:0] strapScheme,
  input wire logic modeExit,
  input wire logic wdHalfElapsed,
  input wire logic intEvent,
  input wire logic intAck,
  input wire logic lpEntryReq,
  input wire logic lpKeyOk,
  input wire logic dbgResClr,
  output logic intN,
  output logic safeN,
  output logic [3:0] modeState,
  output logic wdExtendEn,
  output logic [1:0] failSafeScheme,
  output logic dbgResFlag,
  output logic lpEntryGrant,
  output logic frameErr
);
  smec_mode_t mode;
  smec_mode_t next_mode;
  logic [7:0] misc;
  logic [5:0] lfsr;
  logic [5:0] keyQ;
  logic keyValid;
  logic sclkQ;
  logic csQ;
  logic [15:0] rxSr;
  logic [15:0] txSr;
  logic [4:0] bitCnt;

  // Serial pin edges, pins are synchronous to the core clock
  wire logic sclkRise = spiSclk & ~sclkQ;
  wire logic sclkFall = ~spiSclk & sclkQ;
  wire logic csFall = ~spiCsN & csQ;
  wire logic frameEnd = spiCsN & ~csQ & (bitCnt == 5'(FRAME_BITS));
  wire logic midFrame = ~spiCsN & sclkFall & (bitCnt == 5'(FRAME_BITS / 2));

  // Frame fields
  wire logic isWrite = rxSr[FRAME_WR_BIT];
  wire logic [4:0] addr = rxSr[13:9];
  wire logic [7:0] data = rxSr[7:0];
  wire logic [4:0] earlyAddr = rxSr[5:1];
  wire logic keyRead = (rxSr[7:0] == READ_KEY_CMD[15:8]);
  wire logic parityOk = ~misc[MISC_PARITY] | ~(^rxSr);
  wire logic wrOk = frameEnd & isWrite & parityOk;
  wire logic miscWr = wrOk & (addr == ADDR_MISC);
  wire logic specWr = wrOk & (addr == ADDR_SPECIAL) & keyValid;
  wire logic keyInv = (data[5:0] == ~keyQ);
  wire logic keySafe = (data[5:0] == {keyQ[5:4], ~keyQ[3:0]});
  wire logic [1:0] tgt = data[7:6];

  // override code to scheme number, B3=3 down to A=0
  wire logic [1:0] swScheme = ~misc[1:0];
  wire logic ovrOn = misc[MISC_OVR];
  wire logic strapMismatch = ovrOn & (swScheme != strapScheme);
  wire logic halfInt = wdHalfElapsed & misc[MISC_HALFWD] & (mode == SMEC_XWD);
  wire logic intTrig = intEvent | halfInt | (strapMismatch & ~dbgResFlag);
  wire logic safeReq = specWr & (tgt == TGT_CONFIG) & keySafe & (mode == SMEC_CONFIG);

  // Mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      SMEC_NORMAL: begin
        if (specWr && tgt == TGT_CONFIG && keyInv) next_mode = SMEC_CONFIG;
      end
      SMEC_CONFIG: begin
        if (modeExit) next_mode = SMEC_NORMAL;
      end
      SMEC_XWD: begin
        if (modeExit) next_mode = SMEC_NORMAL;
      end
      SMEC_RESET: begin
        if (modeExit) next_mode = SMEC_CONFIG;
      end
      default: next_mode = SMEC_CONFIG;
    endcase
    if (mode != SMEC_RESET && specWr && keyInv) begin
      if (tgt == TGT_RESET) next_mode = SMEC_RESET;
      else if (tgt == TGT_XWD) next_mode = SMEC_XWD;
    end
  end

  // Mode register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mode <= SMEC_CONFIG;
    else if (clkEn) mode <= next_mode;
  end

  // Serial receive, transmit and bit counting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ <= 1'b0;
      csQ <= 1'b1;
      rxSr <= 16'h0000;
      txSr <= 16'h0000;
      bitCnt <= 5'h00;
    end else if (clkEn) begin
      sclkQ <= spiSclk;
      csQ <= spiCsN;
      if (csFall) begin
        bitCnt <= 5'h00;
        txSr <= 16'h0000;
      end else if (!spiCsN && sclkRise) begin
        rxSr <= {rxSr[14:0], spiMosi};
        bitCnt <= bitCnt + 5'h01;
      end else if (midFrame) begin
        // key in low byte of read answer
        if (keyRead) txSr <= {2'h0, lfsr, 8'h00};
        else if (!rxSr[6] && earlyAddr == ADDR_MISC) txSr <= {misc, 8'h00};
        else txSr <= 16'h0000;
      end else if (!spiCsN && sclkFall && bitCnt != 5'h00) begin
        txSr <= {txSr[14:0], 1'b0};
      end
    end
  end

  // Random key generator and captured key
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= KEY_SEED;
      keyQ <= 6'h00;
      keyValid <= 1'b0;
    end else if (clkEn) begin
      lfsr <= {lfsr[4:0], lfsr[5] ^ lfsr[4]};
      if (midFrame && keyRead) keyQ <= lfsr;
      // key armed by a complete read frame
      if (frameEnd && rxSr == READ_KEY_CMD) keyValid <= 1'b1;
      else if (specWr) keyValid <= 1'b0;
    end
  end

  // Setup register and status outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      misc <= MISC_RESET;
      safeN <= 1'b1;
      dbgResFlag <= 1'b0;
      lpEntryGrant <= 1'b0;
      frameErr <= 1'b0;
      modeState <= 4'(SMEC_CONFIG);
      wdExtendEn <= 1'b0;
      failSafeScheme <= 2'h0;
    end else if (clkEn) begin
      if (miscWr && mode == SMEC_CONFIG) misc <= data;
      if (safeReq) safeN <= 1'b0;
      if (strapMismatch) dbgResFlag <= 1'b1;
      else if (dbgResClr) dbgResFlag <= 1'b0;
      lpEntryGrant <= lpEntryReq & (~misc[MISC_KEYREQ] | lpKeyOk);
      frameErr <= frameEnd & isWrite & ~parityOk;
      modeState <= 4'(next_mode);
      wdExtendEn <= (next_mode == SMEC_XWD);
      failSafeScheme <= ovrOn ? swScheme : strapScheme;
    end
  end

  assign spiMiso = txSr[15];

  // Interrupt pin shaper
  smec_int_pulse #(
    .LONG_CYC(INT_LONG),
    .SHORT_CYC(INT_SHORT_CYC)
  ) uIntPulse (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .trigger(intTrig),
    .levelMode(misc[MISC_INTLVL]),
    .shortWidth(misc[MISC_INTW]),
    .intAck(intAck),
    .intN(intN)
  );
endmodule : smec_top
`default_nettype wire

// [bench/smec_props.sv]
// Checker on the mode, fail-safe, flag and grant outputs
`default_nettype none
module smec_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic lpEntryReq,
  input wire logic dbgResClr,
  input wire logic safeN,
  input wire logic [3:0] modeState,
  input wire logic wdExtendEn,
  input wire logic dbgResFlag,
  input wire logic lpEntryGrant,
  input wire logic frameErr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  mode_one_hot_a: assert property ($onehot(modeState)) else $error("mode not one-hot");
  ext_wd_flag_a: assert property (wdExtendEn == modeState[2]) else $error("extend flag off mode");
  safe_in_config_a: assert property ($fell(safeN) |-> modeState == 4'h2) else $error("safe outside config");
  safe_held_a: assert property (!safeN |=> !safeN) else $error("safe released");
  lp_grant_cause_a: assert property (lpEntryGrant |-> $past(lpEntryReq)) else $error("grant without request");
  frame_err_pulse_a: assert property (frameErr |=> !frameErr) else $error("error pulse too long");
  bad_parity_mode_a: assert property (frameErr |-> modeState == $past(modeState, 3)) else $error("mode moved");
  dbg_clear_cause_a: assert property ($fell(dbgResFlag) |-> $past(dbgResClr)) else $error("flag lost");
endmodule : smec_props
`default_nettype wire

// [bench/smec_spi_master.sv]
// Serial master model that runs one sixteen-bit frame at a time
`default_nettype none
module smec_spi_master (
  input wire logic core_clk,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiMosi,
  input wire logic spiMiso
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus, clock parked low
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end
  // Four core cycles per serial half period
  task automatic w4;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : w4
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    spiCsN = 1'b0;
    w4();
    for (int i = 15; i >= 0; i--) begin
      spiMosi = tx[i];
      w4();
      spiSclk = 1'b1;
      rx = {rx[14:0], spiMiso};
      w4();
      spiSclk = 1'b0;
    end
    w4();
    spiCsN = 1'b1;
    spiMosi = ~spiMosi; // Stale data is not left on the line
    w4();
  endtask : xfer
endmodule : smec_spi_master
`default_nettype wire

// [bench/smec_top_tb.sv]
// Self-checking bench for the secured mode entry block
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %0t mismatch", $time); end end
module smec_top_tb
  import smec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst_n, spiCsN, spiSclk, spiMosi, spiMiso, modeExit, wdHalfElapsed, intEvent, intAck;
  logic lpEntryReq, lpKeyOk, dbgResClr, intN, safeN, wdExtendEn, dbgResFlag, lpEntryGrant, frameErr, parOn;
  logic [1:0] strapScheme, failSafeScheme;
  logic [3:0] modeState;
  logic [7:0] rb;
  logic [15:0] rx;
  int error_cnt = 0, compares = 0, errSeen = 0, grants = 0, n;
  // Rows: exit first, target, key kind (0 inverted, 1 safe, 2 raw), mode, safe
  logic [9:0] rows [7] = '{10'b0_01_00_0010_1, 10'b0_10_00_0100_1, 10'b0_01_00_0100_1,
    10'b0_00_10_0100_1, 10'b0_11_00_0100_1, 10'b1_00_00_1000_1, 10'b1_01_01_0010_0};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    errSeen += (frameErr === 1'b1);
    grants += (lpEntryGrant === 1'b1);
  end
  smec_spi_master m_u (.core_clk(core_clk), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso));
  smec_top #(.INT_LONG(200)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .strapScheme(strapScheme), .modeExit(modeExit),
    .wdHalfElapsed(wdHalfElapsed), .intEvent(intEvent), .intAck(intAck), .lpEntryReq(lpEntryReq),
    .lpKeyOk(lpKeyOk), .dbgResClr(dbgResClr), .intN(intN), .safeN(safeN), .modeState(modeState),
    .wdExtendEn(wdExtendEn), .failSafeScheme(failSafeScheme), .dbgResFlag(dbgResFlag),
    .lpEntryGrant(lpEntryGrant), .frameErr(frameErr));
  // Even parity over the frame when enabled, else zero
  function automatic logic [15:0] par(input logic [15:0] f);
    par = f;
    par[8] = parOn & ^{f[15:9], f[7:0]};
  endfunction : par
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge core_clk);
    #1;
    s = 1'b0;
  endtask : pulse
  task automatic setw(input logic [7:0] v);
    m_u.xfer(par({7'h28, 1'b0, v}), rx);
  endtask : setw
  task automatic rd;
    m_u.xfer(16'h1100, rx);
    rb = rx[7:0];
  endtask : rd
  // Key read, then write with the chosen key form
  task automatic spec(input logic [1:0] tgt, input logic [1:0] op);
    logic [5:0] k;
    m_u.xfer(READ_KEY_CMD, rx);
    `CHK(rx[7:6], 2'h0)
    k = (op == 2'h0) ? ~rx[5:0] : (op == 2'h1) ? {rx[5:4], ~rx[3:0]} : rx[5:0];
    m_u.xfer(par({7'h29, 1'b0, tgt, k}), rx);
  endtask : spec
  // Counts low cycles of the interrupt pin over a fixed span
  task automatic intw(ref logic s);
    repeat (300) @(posedge core_clk);
    #1;
    pulse(s);
    n = 0;
    repeat (3000) begin
      @(posedge core_clk);
      n += (intN === 1'b0);
    end
    #1;
  endtask : intw
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rst_n, modeExit, wdHalfElapsed, intEvent, intAck, lpEntryReq, lpKeyOk, dbgResClr, parOn} = '0;
    strapScheme = 2'h3;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    `CHK(modeState, 4'h2)
    pulse(modeExit);
    foreach (rows[i]) begin
      if (rows[i][9]) pulse(modeExit);
      spec(rows[i][8:7], rows[i][6:5]);
      `CHK(modeState, rows[i][4:1])
      `CHK(safeN, rows[i][0])
      $display("mode row %0d done", i);
    end
    for (int c = 4; c < 8; c++) begin
      setw(c[7:0]);
      `CHK(failSafeScheme, 2'(7 - c))
    end
    `CHK(dbgResFlag, 1'b1)
    setw(8'h04);
    pulse(dbgResClr);
    `CHK(dbgResFlag, 1'b0)
    strapScheme = 2'h1;
    setw(8'h00);
    `CHK(failSafeScheme, 2'h1)
    pulse(lpEntryReq);
    setw(8'h80);
    pulse(lpEntryReq);
    lpKeyOk = 1'b1;
    pulse(lpEntryReq);
    // Grant stands one cycle after the request edge, let the counter see it
    @(posedge core_clk);
    #1;
    `CHK(grants, 2)
    setw(8'h40);
    parOn = 1'b1;
    m_u.xfer(par(16'h5044) ^ 16'h0100, rx);
    rd();
    `CHK(rb, 8'h40)
    `CHK(errSeen, 1)
    intw(intEvent);
    `CHK(n, 200)
    setw(8'h50);
    intw(intEvent);
    `CHK(n, 2500)
    setw(8'h60);
    intw(intEvent);
    `CHK(n, 3000)
    pulse(intAck);
    `CHK(intN, 1'b1)
    setw(8'h48);
    spec(2'h2, 2'h0);
    intw(wdHalfElapsed);
    `CHK(n, 200)
    setw(8'h40);
    rd();
    `CHK(rb, 8'h48)
    $display("setup and interrupt tests done");
    // Mid-run reset drops the latched fail-safe pin and the setup value
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    `CHK(safeN, 1'b1)
    `CHK(modeState, 4'h2)
    rd();
    `CHK(rb, 8'h00)
    $display("mid-run reset test done");
    final_report();
  end
endmodule : smec_top_tb
bind smec_top smec_props chk_u (.core_clk(core_clk), .rst_n(rst_n), .lpEntryReq(lpEntryReq),
  .dbgResClr(dbgResClr), .safeN(safeN), .modeState(modeState), .wdExtendEn(wdExtendEn),
  .dbgResFlag(dbgResFlag), .lpEntryGrant(lpEntryGrant), .frameErr(frameErr));
`default_nettype wire
